/* src/isc_pkg.sv */
package isc_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses on the slave port)
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_CTRL0 = 5'h00;  // bus_control_0
   localparam logic [4:0] OFS_FLAG  = 5'h04;  // bus_flag_register
   localparam logic [4:0] OFS_STAT  = 5'h08;  // Sticky event status, read only
   localparam logic [4:0] OFS_CLR   = 5'h0C;  // Write one to clear status
   localparam logic [4:0] OFS_IEN   = 5'h10;  // Interrupt enable

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int B_BUS_EN    = 7;  // bus_control_0: bus_enable
   localparam int B_LEAVE     = 6;  // bus_control_0: leave_communication
   localparam int B_ACK_EN    = 2;  // bus_control_0: ack_enable
   localparam int B_START     = 1;  // bus_control_0: start_trigger
   localparam int B_STOP      = 0;  // bus_control_0: stop_trigger
   localparam int B_START_CLEAR_FLAG      = 7;  // bus_flag_register: start_clear_flag
   localparam int B_BUSY      = 6;  // bus_flag_register: bus_busy_flag
   localparam int B_RSV_DIS   = 0;  // bus_flag_register: reservation_disable
   localparam int EV_STARTED  = 0;  // Start or restart put on the bus
   localparam int EV_CLEARED  = 1;  // Trigger refused, start-clear flag set
   localparam int EV_ARB_LOST = 2;  // Arbitration lost
   localparam int EV_NUM      = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]        RST_CTRL0 = 8'h00;
   localparam logic              RST_RSV   = 1'b0;
   localparam logic [EV_NUM-1:0] RST_IEN   = 3'h0;

   // ----------------------------------------------------------------
   // Start condition timing at a 100 ns clock
   // ----------------------------------------------------------------
   localparam int CLK_NS     = 100;
   localparam int T_SU_NS    = 4700;  // Start setup, clock high before fall
   localparam int T_HD_NS    = 4000;  // Start hold, data low before clock low
   localparam int SU_CYC     = (T_SU_NS + CLK_NS - 1) / CLK_NS;
   localparam int HD_CYC     = (T_HD_NS + CLK_NS - 1) / CLK_NS;
   localparam int TCNT_W     = 7;

   typedef enum logic [2:0] {
      GS_IDLE, GS_REL_SDA, GS_REL_SCL, GS_SETUP, GS_HOLD, GS_DONE
   } isc_gen_state_t;

endpackage

/* src/isc_start_gen.sv */
`timescale 1ns/1ps
module isc_start_gen
   import isc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic go,
   input  wire logic abort,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      active,
   output logic      sdaLow,
   output logic      sclLow,
   output logic      done
);

   isc_gen_state_t    state_q, state_d;
   logic [TCNT_W-1:0] cnt_q, cnt_d;

   // ----------------------------------------------------------------
   // Start waveform: release lines, wait, data falls with clock high
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         GS_IDLE: begin
            if (go) begin
               state_d = GS_REL_SDA;
            end
         end
         GS_REL_SDA: begin
            // Clock held low only while data is still low
            if (sdaIn) begin
               state_d = GS_REL_SCL;
            end
         end
         GS_REL_SCL: begin
            // Wait out any stretching by a slave
            if (sclIn) begin
               state_d = GS_SETUP;
               cnt_d   = TCNT_W'(SU_CYC - 1);
            end
         end
         GS_SETUP: begin
            if (cnt_q == '0) begin
               state_d = GS_HOLD;
               cnt_d   = TCNT_W'(HD_CYC - 1);
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         GS_HOLD: begin
            if (cnt_q == '0) begin
               state_d = GS_DONE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         GS_DONE: begin
            state_d = GS_IDLE;
         end
         default: begin
            state_d = GS_IDLE;
         end
      endcase
      if (abort) begin
         state_d = GS_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= GS_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Data low only after setup with clock high; clock low once held
   // Clock kept low while data rises, else a released data line is a stop;
   // on an idle bus data is already high, so no stray clock pulse appears
   assign active = (state_q != GS_IDLE);
   assign sdaLow = (state_q == GS_HOLD) || (state_q == GS_DONE);
   assign sclLow = ((state_q == GS_REL_SDA) && !sdaIn) || (state_q == GS_DONE);
   assign done   = (state_q == GS_DONE);

endmodule

/* src/isc_start_trigger.sv */
`timescale 1ns/1ps
module isc_start_trigger
   import isc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Avalon-MM slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Two-wire bus pins
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sclOut,
   output logic             sclOe,
   output logic             sdaOut,
   output logic             sdaOe,
   // From the rest of the controller
   input  wire logic        masterWait,
   input  wire logic        sclHoldReq,
   input  wire logic        arbLost,
   input  wire logic        ackSlot,
   input  wire logic        addrPhase,
   input  wire logic        addrMatch,
   input  wire logic        extCode,
   // To the rest of the controller
   output logic             isMaster,
   output logic             stopTrigger,
   output logic             startDone,
   output logic             irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic              waitReq_q;
   logic [31:0]       rdData_q;
   logic              busEn_q;
   logic              ackEn_q;
   logic              stopTrg_q;
   logic              startTrg_q, startTrg_d;
   logic              rsvDis_q;
   logic              start_clear_flag_q, start_clear_flag_d;
   logic              busy_q, busy_d;
   logic              master_q, master_d;
   logic              sclPrev_q;
   logic              sdaPrev_q;
   logic              sclOe_q, sdaOe_q;
   logic              startDone_q;
   logic [EV_NUM-1:0] sts_q, sts_d;
   logic [EV_NUM-1:0] ien_q;
   logic              irq_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire       req        = read | write;
   wire       acc        = req & ~waitReq_q;
   wire       wrAcc      = write & ~waitReq_q;
   wire       hitCtrl    = (address == OFS_CTRL0);
   wire       hitFlag    = (address == OFS_FLAG);
   wire       hitStat    = (address == OFS_STAT);
   wire       hitClr     = (address == OFS_CLR);
   wire       hitIen     = (address == OFS_IEN);
   wire       wrCtrl     = wrAcc & hitCtrl;
   wire       wrFlag     = wrAcc & hitFlag;
   wire       wrClr      = wrAcc & hitClr;
   wire       wrIen      = wrAcc & hitIen;
   wire       newBusEn   = writedata[B_BUS_EN];
   wire       setStart   = wrCtrl & writedata[B_START] & newBusEn;
   wire       leaveComm  = wrCtrl & writedata[B_LEAVE];

   // Read mux, start trigger and leave bits always read as zero
   wire [7:0] ctrlRd = {busEn_q, 1'b0, 3'h0, ackEn_q, 1'b0, stopTrg_q};
   wire [7:0] flagRd = {start_clear_flag_q & busEn_q, busy_q & busEn_q, 5'h00, rsvDis_q};
   wire [7:0] rdMux  = hitCtrl ? ctrlRd :
                       hitFlag ? flagRd :
                       hitStat ? {{(8-EV_NUM){1'b0}}, sts_q} :
                       hitIen  ? {{(8-EV_NUM){1'b0}}, ien_q} :
                       8'h00;

   // ----------------------------------------------------------------
   // Bus line observation: start and stop seen on the pins
   // ----------------------------------------------------------------
   wire startSeen = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
   wire stopSeen  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;

   // ----------------------------------------------------------------
   // Start generator hookup
   // ----------------------------------------------------------------
   logic genActive;
   logic genSdaLow;
   logic genSclLow;
   logic genDone;

   // Launch: idle bus, or master past its wait for a restart
   wire idleGo    = startTrg_q & ~busy_q & ~master_q;
   wire restartGo = startTrg_q & master_q & ~masterWait;
   wire genGo     = busEn_q & ~genActive & (idleGo | restartGo);
   wire genAbort  = arbLost | ~busEn_q | leaveComm;

   isc_start_gen u_gen (
      .clk    (clk),
      .rst_b  (rst_b),
      .go     (genGo),
      .abort  (genAbort),
      .sclIn  (sclIn),
      .sdaIn  (sdaIn),
      .active (genActive),
      .sdaLow (genSdaLow),
      .sclLow (genSclLow),
      .done   (genDone)
   );

   // ----------------------------------------------------------------
   // Start trigger, start-clear flag, master and busy tracking
   // ----------------------------------------------------------------
   wire othersBusy = busy_q & ~master_q;

   always_comb begin
      startTrg_d = startTrg_q;
      start_clear_flag_d     = start_clear_flag_q;
      if (setStart) begin
         if (othersBusy && rsvDis_q) begin
            startTrg_d = 1'b0;
            start_clear_flag_d     = 1'b1;
         end else begin
            startTrg_d = 1'b1;
         end
      end
      if (genDone || arbLost) begin
         startTrg_d = 1'b0;
      end
      if (leaveComm) begin
         startTrg_d = 1'b0;
      end
      if (!busEn_q || (wrCtrl && !newBusEn)) begin
         startTrg_d = 1'b0;
         start_clear_flag_d     = 1'b0;
      end
      // A start put on the bus by the generator clears the old refusal
      if (genDone && !setStart) begin
         start_clear_flag_d = 1'b0;
      end
   end

   always_comb begin
      master_d = master_q;
      busy_d   = busy_q;
      if (startSeen || genDone) begin
         busy_d = 1'b1;
      end
      if (stopSeen) begin
         busy_d   = 1'b0;
         master_d = 1'b0;
      end
      if (genDone) begin
         master_d = 1'b1;
      end
      if (arbLost || leaveComm) begin
         master_d = 1'b0;
      end
      if (!busEn_q) begin
         busy_d   = 1'b0;
         master_d = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Acknowledge control
   // ----------------------------------------------------------------
   // Address phase: match forces ack, ack_enable only for extension codes
   wire ackAddr  = addrMatch | (extCode & ackEn_q);
   wire ackData  = ackEn_q;
   wire ackDrive = busEn_q & ackSlot & (addrPhase ? ackAddr : ackData);

   // Pin drive: generator owns the lines while it runs
   wire sdaOe_d = busEn_q & (genActive ? genSdaLow : ackDrive);
   wire sclOe_d = busEn_q & (genActive ? genSclLow : sclHoldReq);

   // ----------------------------------------------------------------
   // Interrupt events
   // ----------------------------------------------------------------
   wire [EV_NUM-1:0] evt = {arbLost & master_q, setStart & othersBusy & rsvDis_q, genDone};

   // Set wins over a clear in the same cycle
   always_comb begin
      sts_d = sts_q;
      if (wrClr) begin
         sts_d = sts_q & ~writedata[EV_NUM-1:0];
      end
      sts_d = sts_d | evt;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Slave handshake: one wait cycle, then the access completes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         waitReq_q <= 1'b1;
         rdData_q  <= '0;
      end else begin
         waitReq_q <= ~(req & waitReq_q);
         if (read && waitReq_q) begin
            rdData_q <= {24'h000000, rdMux};
         end
      end
   end

   // Control register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busEn_q   <= RST_CTRL0[B_BUS_EN];
         ackEn_q   <= RST_CTRL0[B_ACK_EN];
         stopTrg_q <= RST_CTRL0[B_STOP];
      end else if (wrCtrl) begin
         busEn_q   <= newBusEn;
         ackEn_q   <= writedata[B_ACK_EN];
         stopTrg_q <= writedata[B_STOP] & newBusEn;
      end
   end

   // Flag register, reservation control
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsvDis_q <= RST_RSV;
      end else if (wrFlag) begin
         rsvDis_q <= writedata[B_RSV_DIS];
      end
   end

   // Trigger and bus state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         startTrg_q <= 1'b0;
         start_clear_flag_q     <= 1'b0;
         busy_q     <= 1'b0;
         master_q   <= 1'b0;
         sclPrev_q  <= 1'b1;
         sdaPrev_q  <= 1'b1;
      end else begin
         startTrg_q <= startTrg_d;
         start_clear_flag_q     <= start_clear_flag_d;
         busy_q     <= busy_d;
         master_q   <= master_d;
         sclPrev_q  <= sclIn;
         sdaPrev_q  <= sdaIn;
      end
   end

   // Pins, done pulse and interrupt
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sdaOe_q     <= 1'b0;
         sclOe_q     <= 1'b0;
         startDone_q <= 1'b0;
         sts_q       <= '0;
         ien_q       <= RST_IEN;
         irq_q       <= 1'b0;
      end else begin
         sdaOe_q     <= sdaOe_d;
         sclOe_q     <= sclOe_d;
         startDone_q <= genDone;
         sts_q       <= sts_d;
         if (wrIen) begin
            ien_q <= writedata[EV_NUM-1:0];
         end
         irq_q <= |(sts_d & (wrIen ? writedata[EV_NUM-1:0] : ien_q));
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign readdata    = rdData_q;
   assign waitrequest = waitReq_q;
   assign sclOe       = sclOe_q;
   assign sdaOe       = sdaOe_q;
   assign sclOut      = 1'b0;   // Open drain, only ever pulls low
   assign sdaOut      = 1'b0;
   assign isMaster    = master_q;
   assign stopTrigger = stopTrg_q;
   assign startDone   = startDone_q;
   assign irq         = irq_q;

endmodule

/* testbench/isc_bus_peer.sv */
`timescale 1ns/1ps
module isc_bus_peer (
   input  wire logic clk,
   input  wire logic sclOe,
   input  wire logic sdaOe,
   output logic      sclIn,
   output logic      sdaIn
);
   logic sclLow_q = 1'b0;
   logic sdaLow_q = 1'b0;

   // Open drain lines with pull-up
   assign sclIn = !(sclOe || sclLow_q);
   assign sdaIn = !(sdaOe || sdaLow_q);

   // Another master claims the bus, then holds the clock low
   task automatic put_start();
      sdaLow_q <= 1'b1;
      repeat (50) @(posedge clk);
      sclLow_q <= 1'b1;
      repeat (10) @(posedge clk);
   endtask

   // Data rises while clock is high: bus released
   task automatic put_stop();
      sdaLow_q <= 1'b1;
      repeat (10) @(posedge clk);
      sclLow_q <= 1'b0;
      repeat (50) @(posedge clk);
      sdaLow_q <= 1'b0;
      repeat (50) @(posedge clk);
   endtask
endmodule

/* testbench/isc_start_trigger_assertions.sv */
`timescale 1ns/1ps
module isc_chk
   import isc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [4:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        sclIn,
   input wire logic        sclOe,
   input wire logic        sdaOe,
   input wire logic        ackSlot,
   input wire logic        addrPhase,
   input wire logic        addrMatch,
   input wire logic        extCode,
   input wire logic        isMaster,
   input wire logic        startDone
);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic       en_q;
   logic [6:0] run_q;
   wire        ctrlWr = write && !waitrequest && address == OFS_CTRL0;
   wire        heldLow = sdaOe && sclIn;

   // Shadow of bus_enable, taken from accepted writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) en_q <= 1'b0;
      else if (ctrlWr) en_q <= writedata[B_BUS_EN];
   end

   // Cycles of data pulled low while clock is high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) run_q <= 7'h00;
      else if (!heldLow) run_q <= 7'h00;
      else if (run_q != 7'h7F) run_q <= run_q + 7'h01;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence sAccess;
      (read || write) && waitrequest;
   endsequence
   sequence sStartHeld;
      run_q >= 7'h26;
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   wait_answer_a: assert property (sAccess |=> !waitrequest) else $error("no answer to access");
   wait_pulse_a: assert property (!waitrequest |=> waitrequest) else $error("waitrequest low too long");
   start_hold_a: assert property ($rose(sclOe) && startDone |-> sStartHeld)
      else $error("start hold too short");
   start_master_a: assert property ($rose(startDone) |-> ##[0:1] isMaster)
      else $error("no master after start");
   addr_ack_a: assert property (en_q && ackSlot && addrPhase && addrMatch |=> sdaOe)
      else $error("matched address not acknowledged");
   addr_nack_a: assert property (en_q && ackSlot && addrPhase && !addrMatch && !extCode && !isMaster
      |=> !sdaOe) else $error("acknowledge on unmatched address");
   off_quiet_a: assert property (!en_q [*3] |-> !startDone && !sdaOe)
      else $error("activity while disabled");
   trig_read_a: assert property (read && !waitrequest && address == OFS_CTRL0
      |-> readdata[B_START] == 1'b0 && readdata[31:8] == 24'h0) else $error("trigger reads one");
   flag_off_a: assert property (read && !waitrequest && address == OFS_FLAG && !en_q
      |-> readdata[B_START_CLEAR_FLAG] == 1'b0 && readdata[B_BUSY] == 1'b0) else $error("flags live while disabled");
endmodule

bind isc_start_trigger isc_chk chk (.clk, .rst_b, .address, .read, .write, .writedata, .readdata,
   .waitrequest, .sclIn, .sclOe, .sdaOe, .ackSlot, .addrPhase, .addrMatch, .extCode, .isMaster, .startDone);

/* testbench/test_isc_start_trigger.sv */
`timescale 1ns/1ps
module test_isc_start_trigger;
   import isc_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, waitrequest, irq;
   logic [4:0] address = 5'h00;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic sclIn, sdaIn, sclOe, sdaOe, isMaster, startDone, stopTrigger;
   logic masterWait = 1'b0, sclHoldReq = 1'b0, arbLost = 1'b0;
   logic ackSlot = 1'b0, addrPhase = 1'b0, addrMatch = 1'b0, extCode = 1'b0;
   int nErrors = 0, samplesChecked = 0;

   isc_start_trigger uut (.clk, .rst_b, .address, .read, .write, .writedata, .readdata, .waitrequest,
      .sclIn, .sdaIn, .sclOut(), .sclOe, .sdaOut(), .sdaOe, .masterWait, .sclHoldReq, .arbLost,
      .ackSlot, .addrPhase, .addrMatch, .extCode, .isMaster, .stopTrigger, .startDone, .irq);
   isc_bus_peer peer (.clk, .sclOe, .sdaOe, .sclIn, .sdaIn);

   always #50 clk = ~clk;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      if (nErrors == 0 && samplesChecked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         nErrors++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // One Avalon access, held until waitrequest is seen low
   // Waits for the answer as long as it takes; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic expect_start(input int n, input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge clk);
         if (startDone === 1'b1) seen = 1'b1;
      end
      chk_bit(seen, exp);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      rd(OFS_CTRL0, 32'h00);
      rd(OFS_FLAG, 32'h00);
      rd(OFS_IEN, 32'h00);
      bus(1'b1, 5'h14, 32'hFF);
      rd(5'h14, 32'h00);
      bus(1'b1, OFS_STAT, 32'h07);
      rd(OFS_STAT, 32'h00);
      bus(1'b1, OFS_FLAG, 32'h01);
      rd(OFS_FLAG, 32'h01);
      bus(1'b1, OFS_FLAG, 32'h00);
      bus(1'b1, OFS_CTRL0, 32'h81);
      @(negedge clk);
      chk_bit(stopTrigger, 1'b1);
      rd(OFS_CTRL0, 32'h81);
      bus(1'b1, OFS_CTRL0, 32'h00);
   endtask
   task automatic t_ack();
      bus(1'b1, OFS_CTRL0, 32'h80);
      ackSlot <= 1'b1;
      addrPhase <= 1'b1;
      addrMatch <= 1'b1;
      repeat (3) @(negedge clk);
      chk_bit(sdaOe, 1'b1);
      bus(1'b1, OFS_CTRL0, 32'h84);
      addrMatch <= 1'b0;
      repeat (3) @(negedge clk);
      chk_bit(sdaOe, 1'b0);
      @(posedge clk);
      extCode <= 1'b1;
      repeat (3) @(negedge clk);
      chk_bit(sdaOe, 1'b1);
      // Data phase: ack_enable is honoured
      @(posedge clk);
      extCode <= 1'b0;
      addrPhase <= 1'b0;
      repeat (3) @(negedge clk);
      chk_bit(sdaOe, 1'b1);
      bus(1'b1, OFS_CTRL0, 32'h80);
      repeat (3) @(negedge clk);
      chk_bit(sdaOe, 1'b0);
      @(posedge clk);
      ackSlot <= 1'b0;
   endtask
   task automatic t_start();
      bus(1'b1, OFS_IEN, 32'h07);
      bus(1'b1, OFS_CTRL0, 32'h82);
      expect_start(150, 1'b1);
      chk_bit(isMaster, 1'b1);
      rd(OFS_CTRL0, 32'h80);
      rd(OFS_STAT, 32'h01);
      chk_bit(irq, 1'b1);
      bus(1'b1, OFS_IEN, 32'h00);
      repeat (2) @(negedge clk);
      chk_bit(irq, 1'b0);
      bus(1'b1, OFS_CLR, 32'h07);
      rd(OFS_STAT, 32'h00);
      masterWait <= 1'b1;
      bus(1'b1, OFS_CTRL0, 32'h82);
      expect_start(100, 1'b0);
      @(posedge clk);
      masterWait <= 1'b0;
      expect_start(150, 1'b1);
   endtask
   task automatic t_free();
      peer.put_stop();
      bus(1'b1, OFS_CTRL0, 32'h00);
      bus(1'b1, OFS_CTRL0, 32'h80);
   endtask
   task automatic t_reserve();
      peer.put_start();
      rd(OFS_FLAG, 32'h40);
      bus(1'b1, OFS_CTRL0, 32'h82);
      expect_start(100, 1'b0);
      fork
         peer.put_stop();
         expect_start(250, 1'b1);
      join
   endtask
   task automatic t_refuse();
      bus(1'b1, OFS_FLAG, 32'h01);
      bus(1'b1, OFS_CLR, 32'h07);
      peer.put_start();
      bus(1'b1, OFS_CTRL0, 32'h82);
      rd(OFS_FLAG, 32'hC1);
      rd(OFS_STAT, 32'h02);
      fork
         peer.put_stop();
         expect_start(250, 1'b0);
      join
      bus(1'b1, OFS_FLAG, 32'h00);
   endtask
   task automatic t_abort(input int k);
      peer.put_start();
      bus(1'b1, OFS_CTRL0, 32'h82);
      if (k == 0) begin
         arbLost <= 1'b1;
         @(posedge clk);
         arbLost <= 1'b0;
      end else if (k == 1) begin
         bus(1'b1, OFS_CTRL0, 32'hC0);
      end else if (k == 2) begin
         bus(1'b1, OFS_CTRL0, 32'h00);
         bus(1'b1, OFS_CTRL0, 32'h80);
      end else begin
         // Mid-run reset with a start reserved
         rst_b <= 1'b0;
         repeat (2) @(posedge clk);
         rst_b <= 1'b1;
         rd(OFS_CTRL0, 32'h00);
         bus(1'b1, OFS_CTRL0, 32'h80);
      end
      fork
         peer.put_stop();
         expect_start(250, 1'b0);
      join
   endtask

   // Watchdog on the whole run
   initial begin
      repeat (20000) @(posedge clk);
      nErrors++;
      test_done();
   end

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_ack();
      t_start();
      t_free();
      t_reserve();
      t_free();
      t_refuse();
      for (int k = 0; k < 4; k++) t_abort(k);
      test_done();
   end
endmodule
